// >>> iomc_central.sv
// iomc_central: storage service sequencer of the i/o multiplexer with its special channels
// assumes a storage port that holds one cycle open until memAck, and a
// transfer partner on the same clock; switch and fault lines are asynchronous
`timescale 1ns/1ps
// Function
// - ten-word nondestructive bootload store as channel
// - bootload writes control words and vectors
// - connect delivers start instruction to channel
// - hardware or system software faults reported
// - user faults reported through affected channel
// - wraparound performs service for named channel
// - wraparound data and status registers
// - snapshot captures internal signals on event
// - software reads and writes any scratchpad word
// - gather on writes, scatter on reads
// - list finished raises program interrupt
// - absolute start is lower limit plus relative
// - start plus count checked against upper
// - failed limit check abandons to fault
// - interrupt on done, special, fault
// - interrupt by setting controller cell
// - comm processor request becomes processor interrupt
// - one storage cycle at a time
// - channel control words kept in scratchpad
module iomc_central
    import iomc_pkg::*;
(
    input  wire logic           sys_clk,     // 25 MHz system clock
    input  wire logic           reset,       // synchronous, active high
    input  wire logic           clkEn,       // freezes all state when low
    input  wire logic           bootPin,     // bootload switch, asynchronous
    input  wire logic           sysFaultPin, // hardware fault line, asynchronous
    input  wire logic           commIrqPin,  // comm processor request, asynchronous
    input  wire iomc_cmd_t      cmd,         // software instruction
    output logic                cmdReady,    // instruction taken when high with valid
    output iomc_rsp_t           rsp,         // answer to a read instruction
    output iomc_mreq_t          memReq,      // storage cycle request
    input  wire logic           memAck,      // storage cycle complete
    input  wire logic [W-1:0]   memRdata,    // read data, valid with memAck
    output iomc_intr_t          intr,        // interrupt cell set pulse
    output iomc_conn_t          conn,        // connect instruction pulse
    input  wire logic           specialEv,   // peripheral special condition pulse
    input  wire logic [CHW-1:0] specialChan, // channel of that condition
    input  wire logic           inValid,     // scatter word offered
    input  wire logic [W-1:0]   inData,      // scatter word
    output logic                inReady,     // scatter word taken
    output logic                outValid,    // gather word offered
    output logic [W-1:0]        outData,     // gather word
    input  wire logic           outReady,    // gather word taken
    output logic                busy         // sequencer not idle
);
    // ------------------------------------------------------------
    // types and helpers
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        S_IDLE, S_BOOT, S_FETCH, S_XFER, S_WRAP, S_SPAD
    } iomc_state_t;

    // absolute address: lower limit plus relative, with carry
    function automatic logic [AW:0] absAddr(input logic [AW-1:0] lo, input logic [AW-1:0] rel);
        absAddr = {1'b0, lo} + {1'b0, rel};
    endfunction : absAddr

    // limit check; upper limit is one past the last address a block may use
    function automatic logic limFail(input logic [AW:0] a, input logic [CW-1:0] n,
                                     input logic [AW-1:0] lo, input logic [AW-1:0] hi);
        logic [AW:0] e;
        e = a + {{(AW+1-CW){1'b0}}, n};
        limFail = a[AW] || (a[AW-1:0] < lo) || (e > {1'b0, hi});
    endfunction : limFail

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    iomc_state_t    st_q, st_d;
    logic [2:0]     bootSy_q, faultSy_q, commSy_q;     // two-flop sync plus edge stage
    logic           bootPend_q, bootPend_d;
    logic           cmdRdy_q, cmdRdy_d;
    iomc_rsp_t      rsp_q, rsp_d;
    iomc_mreq_t     memReq_q, memReq_d;
    iomc_intr_t     intr_q, intr_d;
    iomc_conn_t     conn_q, conn_d;
    logic [AW-1:0]  lo_q, lo_d, hi_q, hi_d, ptr_q, ptr_d, addr_q, addr_d;
    logic [CW-1:0]  cnt_q, cnt_d;
    logic [CHW-1:0] chan_q, chan_d;
    logic           last_q, last_d, dirWr_q, dirWr_d;
    logic [3:0]     idx_q, idx_d;
    logic [1:0]     svc_q, svc_d;
    logic [W-1:0]   wrapData_q, wrapData_d, wrapStat_q, wrapStat_d, snap_q, snap_d;
    logic [1:0]     snapSel_q, snapSel_d;
    logic           snapArm_q, snapArm_d;
    logic           pSys_q, pSys_d, pUsr_q, pUsr_d, pDone_q, pDone_d;
    logic           pSpec_q, pSpec_d, pComm_q, pComm_d;
    logic [CHW-1:0] cUsr_q, cUsr_d, cDone_q, cDone_d, cSpec_q, cSpec_d;
    logic [W-1:0]   buf_q [2];
    logic [W-1:0]   buf_d [2];
    logic [1:0]     bufN_q, bufN_d;
    logic           outV_q, outV_d, inRdy_q, inRdy_d, busy_q;

    // ------------------------------------------------------------
    // scratchpad
    // ------------------------------------------------------------
    logic           spWe;
    logic [CHW-1:0] spAddr;
    logic [W-1:0]   spWdata, spRdata;

    iomc_spad u_spad (
        .sys_clk (sys_clk),
        .clkEn   (clkEn),
        .we      (spWe),
        .addr    (spAddr),
        .wdata   (spWdata),
        .rdata   (spRdata)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    logic        memDone, take, push, pop, bootEdge, faultEdge, commEdge;
    logic [3:0]  ev;
    logic [AW:0] a;

    always_comb begin
        st_d = st_q;  bootPend_d = bootPend_q;  rsp_d = '0;  conn_d = '0;  intr_d = '0;
        memReq_d = memReq_q;  lo_d = lo_q;  hi_d = hi_q;  ptr_d = ptr_q;  addr_d = addr_q;
        cnt_d = cnt_q;  chan_d = chan_q;  last_d = last_q;  dirWr_d = dirWr_q;
        idx_d = idx_q;  svc_d = svc_q;  wrapData_d = wrapData_q;  wrapStat_d = wrapStat_q;
        snap_d = snap_q;  snapSel_d = snapSel_q;  snapArm_d = snapArm_q;
        pSys_d = pSys_q;  pUsr_d = pUsr_q;  pDone_d = pDone_q;  pSpec_d = pSpec_q;
        pComm_d = pComm_q;  cUsr_d = cUsr_q;  cDone_d = cDone_q;  cSpec_d = cSpec_q;
        spWe = 1'b0;  spAddr = cmd.chan;  spWdata = cmd.data;
        push = 1'b0;  ev = '0;  a = '0;
        bootEdge  = bootSy_q[1] & ~bootSy_q[2];
        faultEdge = faultSy_q[1] & ~faultSy_q[2];
        commEdge  = commSy_q[1] & ~commSy_q[2];
        take = cmd.valid & cmdRdy_q;
        memDone = memReq_q.valid & memAck;
        if (memDone) begin
            memReq_d.valid = 1'b0;
        end
        if (bootEdge) begin
            bootPend_d = 1'b1;
        end

        case (st_q)
            S_IDLE: begin
                if (take) begin
                    case (cmd.op)
                        OP_CONNECT: conn_d = '{valid: 1'b1, chan: cmd.chan, data: cmd.data};
                        OP_LIMITS: begin
                            lo_d = cmd.addr;
                            hi_d = cmd.data[AW-1:0];
                        end
                        OP_START: begin
                            chan_d  = cmd.chan;
                            ptr_d   = cmd.addr;
                            dirWr_d = cmd.svc[0];
                            spWe    = 1'b1;
                            spWdata = W'(cmd.addr);
                            st_d    = S_FETCH;
                        end
                        // service on behalf of named channel
                        OP_WRAP: begin
                            chan_d = cmd.chan;
                            svc_d  = cmd.svc;
                            a      = absAddr(lo_q, cmd.addr);
                            if (cmd.svc == WRAP_SET) begin
                                wrapData_d = cmd.data;
                                wrapStat_d = W'({cmd.chan, cmd.svc, 1'b0});
                            end else if (limFail(a, CW'(1), lo_q, hi_q)) begin
                                wrapStat_d = W'({cmd.chan, cmd.svc, 1'b1});
                                pUsr_d     = 1'b1;
                                cUsr_d     = cmd.chan;
                                ev[1]      = 1'b1;
                            end else begin
                                memReq_d = '{valid: 1'b1, wr: cmd.svc == WRAP_STORE,
                                             addr: a[AW-1:0], data: wrapData_q};
                                st_d     = S_WRAP;
                            end
                        end
                        OP_SNAP: begin
                            snapSel_d = cmd.svc;
                            snapArm_d = 1'b1;
                        end
                        OP_SPAD_RD: st_d = S_SPAD;
                        OP_SPAD_WR: spWe = 1'b1;
                        OP_STATUS: begin
                            rsp_d.valid = 1'b1;
                            rsp_d.data  = cmd.svc[1] ? snap_q :
                                          (cmd.svc[0] ? wrapStat_q : wrapData_q);
                        end
                        default: st_d = S_IDLE;
                    endcase
                end else if (bootPend_q) begin
                    bootPend_d = 1'b0;
                    idx_d      = '0;
                    st_d       = S_BOOT;
                end
            end
            // copy the fixed store into main storage
            S_BOOT: begin
                if (memDone) begin
                    idx_d = idx_q + 4'h1;
                    if (idx_q == BOOT_WORDS - 4'h1) begin
                        st_d = S_IDLE;
                    end
                end else if (!memReq_q.valid) begin
                    memReq_d = '{valid: 1'b1, wr: 1'b1, addr: BOOT_BASE + AW'(idx_q),
                                 data: BOOT_TAG | W'(idx_q)};
                end
            end
            S_FETCH: begin
                if (memDone) begin
                    a      = absAddr(lo_q, memRdata[DCW_REL_LSB +: AW]);
                    cnt_d  = memRdata[DCW_CNT_LSB +: CW];
                    last_d = memRdata[DCW_LAST_BIT];
                    addr_d = a[AW-1:0];
                    ev[2]  = 1'b1;
                    if (limFail(a, memRdata[DCW_CNT_LSB +: CW], lo_q, hi_q)) begin
                        pUsr_d = 1'b1;
                        cUsr_d = chan_q;
                        ev[1]  = 1'b1;
                        st_d   = S_IDLE;
                    end else begin
                        st_d = S_XFER;
                    end
                end else if (!memReq_q.valid) begin
                    memReq_d = '{valid: 1'b1, wr: 1'b0, addr: ptr_q, data: '0};
                end
            end
            // gather to peripheral or scatter from it
            S_XFER: begin
                if (memDone) begin
                    push   = ~dirWr_q ? 1'b0 : 1'b1;
                    addr_d = addr_q + AW'(1);
                    cnt_d  = cnt_q - CW'(1);
                    ev[3]  = 1'b1;
                end else if (memReq_q.valid) begin
                    st_d = S_XFER;
                end else if (cnt_q == '0) begin
                    if (last_q) begin
                        pDone_d = 1'b1;
                        cDone_d = chan_q;
                        st_d    = S_IDLE;
                    end else begin
                        ptr_d   = ptr_q + AW'(1);
                        spWe    = 1'b1;
                        spAddr  = chan_q;
                        spWdata = W'(ptr_q + AW'(1));
                        st_d    = S_FETCH;
                    end
                end else if (dirWr_q && bufN_q != BUF_FULL) begin
                    memReq_d = '{valid: 1'b1, wr: 1'b0, addr: addr_q, data: '0};
                end else if (!dirWr_q && inValid && inRdy_q) begin
                    memReq_d = '{valid: 1'b1, wr: 1'b1, addr: addr_q, data: inData};
                end
            end
            S_WRAP: begin
                if (memDone) begin
                    if (svc_q == WRAP_LOAD) begin
                        wrapData_d = memRdata;
                    end
                    wrapStat_d = W'({chan_q, svc_q, 1'b0});
                    st_d       = S_IDLE;
                end
            end
            S_SPAD: begin
                rsp_d = '{valid: 1'b1, data: spRdata};
                st_d  = S_IDLE;
            end
            default: st_d = S_IDLE;
        endcase

        // two-entry gather buffer; the sequencer stalls while it is full
        pop      = outV_q & outReady;
        buf_d[0] = buf_q[0];
        buf_d[1] = buf_q[1];
        bufN_d   = bufN_q;
        if (pop) begin
            buf_d[0] = buf_q[1];
            bufN_d   = bufN_d - 2'h1;
        end
        if (push) begin
            buf_d[bufN_d[0]] = memRdata;
            bufN_d           = bufN_d + 2'h1;
        end
        outV_d  = bufN_d != RST_BUFN;
        inRdy_d = (st_d == S_XFER) && !dirWr_d && !memReq_d.valid && (cnt_d != '0);

        // one cell set per cycle, faults first; a new event beats its clear
        if (pSys_q) begin
            intr_d = '{valid: 1'b1, code: INT_SYS_FAULT, chan: '0};
            pSys_d = 1'b0;
        end else if (pUsr_q) begin
            intr_d = '{valid: 1'b1, code: INT_USER_FAULT, chan: cUsr_q};
            pUsr_d = pUsr_d & ev[1];
        end else if (pDone_q) begin
            intr_d  = '{valid: 1'b1, code: INT_DONE, chan: cDone_q};
            pDone_d = pDone_d & (st_q == S_XFER) & (st_d == S_IDLE);
        end else if (pSpec_q) begin
            intr_d  = '{valid: 1'b1, code: INT_SPECIAL, chan: cSpec_q};
            pSpec_d = 1'b0;
        end else if (pComm_q) begin
            intr_d  = '{valid: 1'b1, code: INT_COMM, chan: '0};
            pComm_d = 1'b0;
        end
        // system fault; comm request; special condition
        pSys_d  = pSys_d | faultEdge;
        pSpec_d = pSpec_d | specialEv;
        pComm_d = pComm_d | commEdge;
        if (specialEv) begin
            cSpec_d = specialChan;
        end
        ev[0] = intr_d.valid;
        ev[1] = ev[1] | faultEdge;  // snapshot only; must not hold a user fault pending

        // snapshot of sequencer state, channel and address
        if (snapArm_q && ev[snapSel_q]) begin
            snap_d    = W'({3'(st_q), chan_q, addr_q});
            snapArm_d = take && (cmd.op == OP_SNAP);  // a fresh arm wins over the fire
        end
        cmdRdy_d = (st_d == S_IDLE) && !take && !bootPend_d;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_q <= S_IDLE;  bootSy_q <= '0;  faultSy_q <= '0;  commSy_q <= '0;
            bootPend_q <= 1'b0;  cmdRdy_q <= 1'b0;  rsp_q <= '0;  memReq_q <= '0;
            intr_q <= '0;  conn_q <= '0;  lo_q <= RST_LO;  hi_q <= RST_HI;
            ptr_q <= '0;  addr_q <= '0;  cnt_q <= '0;  chan_q <= '0;  last_q <= 1'b0;
            dirWr_q <= 1'b0;  idx_q <= '0;  svc_q <= '0;  wrapData_q <= '0;
            wrapStat_q <= '0;  snap_q <= '0;  snapSel_q <= '0;  snapArm_q <= 1'b0;
            pSys_q <= 1'b0;  pUsr_q <= 1'b0;  pDone_q <= 1'b0;  pSpec_q <= 1'b0;
            pComm_q <= 1'b0;  cUsr_q <= '0;  cDone_q <= '0;  cSpec_q <= '0;
            buf_q[0] <= '0;  buf_q[1] <= '0;  bufN_q <= RST_BUFN;
            outV_q <= 1'b0;  inRdy_q <= 1'b0;  busy_q <= 1'b0;
        end else if (clkEn) begin
            st_q <= st_d;  bootPend_q <= bootPend_d;  cmdRdy_q <= cmdRdy_d;
            bootSy_q  <= {bootSy_q[1:0], bootPin};
            faultSy_q <= {faultSy_q[1:0], sysFaultPin};
            commSy_q  <= {commSy_q[1:0], commIrqPin};
            rsp_q <= rsp_d;  memReq_q <= memReq_d;  intr_q <= intr_d;  conn_q <= conn_d;
            lo_q <= lo_d;  hi_q <= hi_d;  ptr_q <= ptr_d;  addr_q <= addr_d;
            cnt_q <= cnt_d;  chan_q <= chan_d;  last_q <= last_d;  dirWr_q <= dirWr_d;
            idx_q <= idx_d;  svc_q <= svc_d;  wrapData_q <= wrapData_d;
            wrapStat_q <= wrapStat_d;  snap_q <= snap_d;  snapSel_q <= snapSel_d;
            snapArm_q <= snapArm_d;  pSys_q <= pSys_d;  pUsr_q <= pUsr_d;
            pDone_q <= pDone_d;  pSpec_q <= pSpec_d;  pComm_q <= pComm_d;
            cUsr_q <= cUsr_d;  cDone_q <= cDone_d;  cSpec_q <= cSpec_d;
            buf_q[0] <= buf_d[0];  buf_q[1] <= buf_d[1];  bufN_q <= bufN_d;
            outV_q <= outV_d;  inRdy_q <= inRdy_d;  busy_q <= st_d != S_IDLE;
        end
    end

    // outputs straight from registers
    assign cmdReady = cmdRdy_q;
    assign rsp      = rsp_q;
    assign memReq   = memReq_q;
    assign intr     = intr_q;
    assign conn     = conn_q;
    assign inReady  = inRdy_q;
    assign outValid = outV_q;
    assign outData  = buf_q[0];
    assign busy     = busy_q;
endmodule : iomc_central

// >>> iomc_pkg.sv
// iomc_pkg: constants, codes and carrier types of the i/o multiplexer central logic
// assumes one 25 MHz clock domain and 36-bit storage words
package iomc_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int W          = 36;   // storage word
    localparam int AW         = 18;   // storage address
    localparam int CHW        = 3;    // channel number
    localparam int CW         = 12;   // data control word count field
    localparam int SPAD_DEPTH = 8;    // one control word per channel

    // ------------------------------------------------------------
    // data control word layout
    // ------------------------------------------------------------
    localparam int DCW_REL_LSB  = 0;
    localparam int DCW_CNT_LSB  = 18;
    localparam int DCW_LAST_BIT = 35;  // set on the final word of a list

    // ------------------------------------------------------------
    // bootload store and reset values
    // ------------------------------------------------------------
    localparam logic [3:0]    BOOT_WORDS = 4'hA;
    localparam logic [AW-1:0] BOOT_BASE  = 18'h0_0000;
    localparam logic [W-1:0]  BOOT_TAG   = 36'h7_0000_0000;  // arbitrary image pattern
    localparam logic [AW-1:0] RST_LO     = 18'h0_0000;
    localparam logic [AW-1:0] RST_HI     = 18'h3_FFFF;
    localparam logic [1:0]    RST_BUFN   = 2'h0;
    localparam logic [1:0]    BUF_FULL   = 2'h2;

    // ------------------------------------------------------------
    // instruction, service and interrupt codes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_CONNECT, OP_LIMITS, OP_START, OP_WRAP,
        OP_SNAP, OP_SPAD_RD, OP_SPAD_WR, OP_STATUS
    } iomc_op_t;

    localparam logic [1:0] WRAP_SET   = 2'h0;  // data register from instruction
    localparam logic [1:0] WRAP_STORE = 2'h1;  // data register to storage
    localparam logic [1:0] WRAP_LOAD  = 2'h2;  // storage to data register

    typedef enum logic [2:0] {
        INT_DONE, INT_SPECIAL, INT_USER_FAULT, INT_SYS_FAULT, INT_COMM
    } iomc_icode_t;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic           valid;
        iomc_op_t       op;
        logic [1:0]     svc;
        logic [CHW-1:0] chan;
        logic [AW-1:0]  addr;
        logic [W-1:0]   data;
    } iomc_cmd_t;

    typedef struct packed {
        logic         valid;
        logic [W-1:0] data;
    } iomc_rsp_t;

    typedef struct packed {
        logic          valid;
        logic          wr;
        logic [AW-1:0] addr;
        logic [W-1:0]  data;
    } iomc_mreq_t;

    typedef struct packed {
        logic           valid;
        iomc_icode_t    code;
        logic [CHW-1:0] chan;
    } iomc_intr_t;

    typedef struct packed {
        logic           valid;
        logic [CHW-1:0] chan;
        logic [W-1:0]   data;
    } iomc_conn_t;

endpackage : iomc_pkg

// >>> iomc_spad.sv
// iomc_spad: control-word scratchpad, one word per channel, registered read data
// assumes a single port shared by the central sequencer and software access
`timescale 1ns/1ps
module iomc_spad
    import iomc_pkg::*;
(
    input  wire logic           sys_clk, // system clock
    input  wire logic           clkEn,   // freezes the store when low
    input  wire logic           we,      // write strobe
    input  wire logic [CHW-1:0] addr,    // word select
    input  wire logic [W-1:0]   wdata,   // write data
    output logic      [W-1:0]   rdata    // read data, one cycle after addr
);
    logic [W-1:0] mem [SPAD_DEPTH];

    // read-before-write single port; contents are not reset
    always_ff @(posedge sys_clk) begin
        if (clkEn) begin
            if (we) begin
                mem[addr] <= wdata;
            end
            rdata <= mem[addr];
        end
    end
endmodule : iomc_spad

// >>> iomc_central_props.sv
// iomc_central_props: port assertions of the central sequencer
// assumes one clock domain; bound into every iomc_central
`timescale 1ns/1ps
module iomc_central_props import iomc_pkg::*; (
    input wire logic sys_clk, reset, cmdReady, memAck, busy, // clock, reset, flags
    input wire logic outValid, outReady,                      // gather handshake
    input wire iomc_cmd_t cmd, input wire iomc_rsp_t rsp,    // instruction side
    input wire iomc_mreq_t memReq, input wire iomc_conn_t conn, // storage, connect
    input wire logic [W-1:0] outData                          // gather word
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    logic take;
    assign take = cmd.valid && cmdReady; // instruction taken this edge
    a_take_drops: assert property (take |=> !cmdReady)
        else $error("ready after take");
    a_status_answer: assert property (take && cmd.op == OP_STATUS |=> rsp.valid)
        else $error("no status answer");
    a_spad_answer: assert property (take && cmd.op == OP_SPAD_RD |-> ##2 rsp.valid)
        else $error("no scratchpad answer");
    a_connect_pulse: assert property (take && cmd.op == OP_CONNECT |=>
        conn.valid && conn.chan == $past(cmd.chan) ##1 !conn.valid) else $error("bad connect");
    a_req_hold: assert property (memReq.valid && !memAck |=> $stable(memReq))
        else $error("request moved");
    a_req_gap: assert property (memReq.valid && memAck |=> !memReq.valid)
        else $error("no gap");
    a_gather_hold: assert property (outValid && !outReady |=> outValid && $stable(outData))
        else $error("gather word lost");
    a_reset_quiet: assert property ($fell(reset) |-> !cmdReady && !busy && !memReq.valid)
        else $error("busy after reset");
    c_gather: cover property (outValid && outReady);
    c_spad: cover property (take && cmd.op == OP_SPAD_RD);
    c_cycle: cover property (memReq.valid && memAck);
endmodule : iomc_central_props
bind iomc_central iomc_central_props u_props(.sys_clk, .reset, .cmdReady, .memAck, .busy,
    .outValid, .outReady, .cmd, .rsp, .memReq, .conn, .outData);

// >>> iomc_mem_model.sv
// iomc_mem_model: storage behind the system controller
// assumes requests held until memAck; slow adds three wait cycles
`timescale 1ns/1ps
module iomc_mem_model import iomc_pkg::*; (
    input  wire logic       sys_clk,  // system clock
    input  wire iomc_mreq_t memReq,   // storage request
    input  wire logic       slow,     // add wait cycles
    output logic            memAck,   // cycle complete
    output logic [W-1:0]    memRdata  // read data with memAck
);
    logic [W-1:0] mem [int];
    int           waitCnt = 0;
    initial memAck = 1'b0;
    initial memRdata = '0;
    // one open cycle answered; idle data toggles so stale reads show
    always @(posedge sys_clk) begin
        memAck <= 1'b0;
        memRdata <= ~memRdata;
        if (memReq.valid && !memAck && waitCnt < (slow ? 3 : 0)) waitCnt <= waitCnt + 1;
        else if (memReq.valid && !memAck) begin
            waitCnt <= 0;
            memAck <= 1'b1;
            if (memReq.wr) mem[int'(memReq.addr)] = memReq.data;
            else memRdata <= mem.exists(int'(memReq.addr)) ? mem[int'(memReq.addr)] : '0;
        end
    end
endmodule : iomc_mem_model

// >>> iomc_central_tb.sv
// iomc_central_tb: directed scenarios for the central sequencer
// assumes iomc_mem_model as storage; scatter stream left idle
`timescale 1ns/1ps
module iomc_central_tb import iomc_pkg::*;;
    logic sys_clk = 0, reset = 1, clkEn = 1, bootPin = 0, sysFaultPin = 0, commIrqPin = 0;
    logic specialEv = 0, inValid = 0, outReady = 0, slow = 0, memAck, cmdReady, inReady;
    logic outValid, busy;
    logic [CHW-1:0] specialChan = '0;
    logic [W-1:0] inData = '0, memRdata, outData, gotR;
    iomc_cmd_t cmd = '0;
    iomc_rsp_t rsp;
    iomc_mreq_t memReq;
    iomc_intr_t intr, gotI;
    iomc_conn_t conn, gotC;
    int errors = 0, num_checks = 0;
    iomc_central u_iomc_central(.*);
    iomc_mem_model u_iomc_mem_model(.*);
    initial forever #20 sys_clk = ~sys_clk;
    // hold the last one-cycle answers for later comparison
    always @(posedge sys_clk) begin
        if (rsp.valid) gotR <= rsp.data;
        if (intr.valid) gotI <= intr;
        if (conn.valid) gotC <= conn;
    end
    task automatic cmp(logic [39:0] g, logic [39:0] e);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : cmp
    task automatic issue(iomc_op_t op, logic [1:0] sv, logic [CHW-1:0] ch,
                         logic [AW-1:0] a, logic [W-1:0] d);
        cmd <= '{1'b1, op, sv, ch, a, d};
        do @(posedge sys_clk); while (cmdReady !== 1'b1);
        cmd.valid <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask : issue
    task automatic idle();
        repeat (8) @(posedge sys_clk);
        while (busy !== 1'b0) @(posedge sys_clk);
        repeat (4) @(posedge sys_clk);
    endtask : idle
    task automatic results();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : results
    task automatic t_boot();
        slow <= 1'b1;
        bootPin <= 1'b1;
        repeat (4) @(posedge sys_clk);
        bootPin <= 1'b0;
        idle();
        for (int i = 0; i < 10; i++) cmp(u_iomc_mem_model.mem[i], BOOT_TAG | i);
        slow <= 1'b0;
    endtask : t_boot
    task automatic t_readback();
        issue(OP_SPAD_WR, 2'h0, 3'h5, '0, 36'h5_A5A5_0001);
        issue(OP_SPAD_RD, 2'h0, 3'h5, '0, '0);
        cmp(gotR, 36'h5_A5A5_0001);
        issue(OP_WRAP, WRAP_SET, 3'h0, '0, 36'h1_2345_6789);
        issue(OP_STATUS, 2'h0, 3'h0, '0, '0);
        cmp(gotR, 36'h1_2345_6789);
        issue(OP_WRAP, WRAP_STORE, 3'h1, 18'h0_0040, '0);
        cmp(u_iomc_mem_model.mem[32'h40], 36'h1_2345_6789);
        issue(OP_CONNECT, 2'h0, 3'h3, '0, 36'h0_00C0_FFEE);
        cmp({gotC.chan, gotC.data}, {3'h3, 36'h0_00C0_FFEE});
    endtask : t_readback
    task automatic t_gather();
        for (int i = 0; i < 2; i++) u_iomc_mem_model.mem[32'h110 + i] = 36'h9_0000_0110 + i;
        u_iomc_mem_model.mem[32'h20] = {1'b1, 5'h0, 12'h002, 18'h0_0010};
        u_iomc_mem_model.mem[32'h30] = {1'b1, 5'h0, 12'h020, 18'h0_00F0};
        issue(OP_LIMITS, 2'h0, 3'h0, 18'h0_0100, 36'h0_0000_01FF);
        issue(OP_START, 2'h1, 3'h2, 18'h0_0020, '0);
        repeat (30) @(posedge sys_clk);
        outReady <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            do @(posedge sys_clk); while (outValid !== 1'b1);
            cmp(outData, 36'h9_0000_0110 + i);
        end
        idle();
        cmp({gotI.code, gotI.chan}, {INT_DONE, 3'h2});
        issue(OP_START, 2'h0, 3'h4, 18'h0_0030, '0);
        idle();
        cmp({gotI.code, gotI.chan}, {INT_USER_FAULT, 3'h4});
    endtask : t_gather
    task automatic t_events();
        iomc_icode_t ex [3] = '{INT_SYS_FAULT, INT_SPECIAL, INT_COMM};
        specialChan <= 3'h6;
        for (int k = 0; k < 3; k++) begin
            {sysFaultPin, specialEv, commIrqPin} <= 3'b100 >> k;
            @(posedge sys_clk);
            {sysFaultPin, specialEv, commIrqPin} <= 3'b000;
            repeat (10) @(posedge sys_clk);
            cmp({gotI.code, gotI.chan}, {ex[k], ((k == 1) ? 3'h6 : 3'h0)});
        end
    endtask : t_events
    initial begin
        repeat (20) @(posedge sys_clk);
        reset <= 1'b0;
        repeat (2) @(posedge sys_clk);
        t_boot();
        t_readback();
        t_gather();
        t_events();
        results();
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        results();
    end
endmodule : iomc_central_tb
